/* design/flash_gen.sv */
`timescale 1ns/1ns
module flash_gen #(
   parameter int unsigned HALF_CYCLES = 2
) (
   input  wire logic mclk,
   input  wire logic nrst,
   output logic      tick,
   output logic      level
);
   localparam int unsigned CW = (HALF_CYCLES > 2) ? $clog2(HALF_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

   logic [CW-1:0] cnt_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + CW'(1);
         tick  <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         level <= 1'b0;
      end else if (tick) begin
         level <= ~level;
      end
   end
endmodule

/* design/mode_panel.sv */
`timescale 1ns/1ns
// Overview of operation
// - with the selector at run the block lets the core execute the program and lights the run lamp.
// - moving the selector from run to stop enters the stop state and lights the stop lamp.
// - an overall reset (momentary switch down) erases every RAM area, then initialises them.
// - a reset (switch up) clears flags, timers, counters and image, calls startup block 20, runs.
// - a restart (switch at midpoint) resumes at the interruption point, keeping retained state.
// - in run the run lamp is on and the stop lamp off.
// - a stop from the selector, the programming device or another processor shows steady stop.
// - during initial start and program check both run and stop lamps are dark.
// - a self-caused stop flashes the stop lamp slowly until the selector is set to stop.
// - in stop with an overall reset pending the stop lamp flashes rapidly, run lamp off.
// - a failed acknowledge of a module recorded present (image bytes 0-127 or list) lights a lamp.
// - a reference to an I/O address with no module lights the addressing-error lamp.
// - a program cycle longer than the configured maximum lights the cycle-overrun lamp.
// - while the output-inhibit lamp is lit command output is blocked and outputs go safe.
module mode_panel
   import mode_panel_pkg::*;
#(
   parameter int unsigned SLOW_HALF  = mode_panel_pkg::SLOW_HALF_CYC,
   parameter int unsigned RAPID_HALF = mode_panel_pkg::RAPID_HALF_CYC
) (
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic [31:0]                 hrdata,
   output logic                        hresp,
   input  wire mode_panel_pkg::switch_s sw_pins,
   input  wire mode_panel_pkg::core_s   core,
   output mode_panel_pkg::lamps_s       lamps,
   output mode_panel_pkg::ctl_s         ctl,
   output logic                        irq
);
   switch_s          s1_q, s2_q, s3_q, sw_q;
   mode_state_e      state_q;
   logic             sel_rise, sel_fall;
   logic             self_q, ovr_q;
   logic             slow_lvl, rapid_lvl;
   logic             ack_hit, cyc_over;
   logic [IMAGE_BYTES-1:0] present_q;
   logic [31:0]      cyc_cnt_q, maxcyc_q;
   logic             cyc_flag_q;
   logic [EV_W-1:0]  events, irq_stat_q, irq_mask_q;
   logic             lamp_clr;
   logic             acc, wr_pend_q;
   logic [7:0]       wr_ofs_q;
   logic             rd_stat_clr;
   lamps_s           lamps_d;

   // switch pins are asynchronous; a change is taken once stages two and three agree
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         sw_q <= '0;
      end else begin
         s1_q <= sw_pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            sw_q <= s3_q;
         end
      end
   end

   assign sel_rise = (s2_q == s3_q) && s3_q.run_sel && !sw_q.run_sel;
   assign sel_fall = (s2_q == s3_q) && !s3_q.run_sel && sw_q.run_sel;

   flash_gen #(.HALF_CYCLES(SLOW_HALF)) slow_div (
      .mclk  (mclk),
      .nrst  (nrst),
      .tick  (),
      .level (slow_lvl)
   );

   flash_gen #(.HALF_CYCLES(RAPID_HALF)) rapid_div (
      .mclk  (mclk),
      .nrst  (nrst),
      .tick  (),
      .level (rapid_lvl)
   );

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q <= init_st;
      end else begin
         unique case (state_q)
            init_st: begin
               if (core.init_done) begin
                  state_q <= stop_st;
               end
            end
            stop_st: begin
               if (sel_rise) begin
                  if (s3_q.mc_down) begin
                     state_q <= erase_st;
                  end else if (s3_q.mc_up) begin
                     state_q <= run_st;
                  end else if (!ovr_q) begin
                     state_q <= run_st;
                  end
               end
            end
            erase_st: begin
               if (core.erase_done) begin
                  state_q <= stop_st;
               end
            end
            run_st: begin
               if (sel_fall || core.pg_stop || core.mp_stop || core.self_stop) begin
                  state_q <= stop_st;
               end
            end
         endcase
      end
   end

   // a self stop is only shown as such while the selector still reads run
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         self_q <= 1'b0;
      end else if (sel_fall || state_q != stop_st && state_q != run_st) begin
         self_q <= 1'b0;
      end else if (state_q == run_st && core.self_stop && !core.pg_stop && !core.mp_stop) begin
         self_q <= 1'b1;
      end else if (state_q == stop_st && sel_rise) begin
         self_q <= 1'b0;
      end
   end

   // pending from power-up until an overall reset completes; a held switch re-arms it only at stop
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ovr_q <= OVR_PEND_RST;
      end else if (core.ovr_request || state_q == stop_st && sw_q.mc_down && !sw_q.run_sel) begin
         ovr_q <= 1'b1;
      end else if (state_q == erase_st && core.erase_done) begin
         ovr_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctl <= '0;
      end else begin
         ctl.program_execute   <= (state_q == run_st) && sw_q.run_sel;
         ctl.ram_erase_req     <= state_q == stop_st && sel_rise && s3_q.mc_down;
         ctl.ram_init_req      <= state_q == erase_st && core.erase_done;
         ctl.clear_state_req   <= state_q == stop_st && sel_rise && !s3_q.mc_down
                                  && s3_q.mc_up;
         ctl.restart_startup_block_req <= state_q == stop_st && sel_rise && !s3_q.mc_down
                                  && s3_q.mc_up;
         ctl.startup_block     <= STARTUP_BLOCK;
         ctl.resume_req        <= state_q == stop_st && sel_rise && !s3_q.mc_down
                                  && !s3_q.mc_up && !ovr_q;
         ctl.cmd_output_enable <= !lamps_d.output_inhibit_lamp;
         ctl.outputs_safe      <= lamps_d.output_inhibit_lamp;
      end
   end

   // presence map filled from the core's scan acknowledges after a reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         present_q <= '0;
      end else begin
         if (ctl.clear_state_req || ctl.ram_erase_req) begin
            present_q <= '0;
         end
         if (core.scan_ack) begin
            present_q[core.scan_addr] <= 1'b1;
         end
      end
   end

   assign ack_hit = core.access_fail && ((core.access_addr <= IMAGE_LAST
                    && present_q[core.access_addr[6:0]]) || core.list_hit);

   // cycle timer restarts at each cycle start and reports one overrun per cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cyc_cnt_q  <= '0;
         cyc_flag_q <= 1'b0;
      end else if (state_q != run_st || core.cycle_start) begin
         cyc_cnt_q  <= '0;
         cyc_flag_q <= 1'b0;
      end else begin
         if (cyc_cnt_q != 32'hFFFFFFFF) begin
            cyc_cnt_q <= cyc_cnt_q + 32'h00000001;
         end
         if (cyc_over) begin
            cyc_flag_q <= 1'b1;
         end
      end
   end

   assign cyc_over = state_q == run_st && cyc_cnt_q > maxcyc_q && !cyc_flag_q;
   assign lamp_clr = ctl.clear_state_req || ctl.ram_init_req;

   always_comb begin
      lamps_d = lamps;
      lamps_d.run_lamp = 1'b0;
      lamps_d.stop_lamp = 1'b0;
      if (state_q == run_st && !core.check_active) begin
         lamps_d.run_lamp = 1'b1;
      end else if (state_q == stop_st && !core.check_active) begin
         if (ovr_q) begin
            lamps_d.stop_lamp = rapid_lvl;
         end else if (self_q) begin
            lamps_d.stop_lamp = slow_lvl;
         end else begin
            lamps_d.stop_lamp = 1'b1;
         end
      end
      if (lamp_clr) begin
         lamps_d.acknowledge_timeout_lamp = 1'b0;
         lamps_d.addressing_error_lamp    = 1'b0;
         lamps_d.cycle_overrun_lamp       = 1'b0;
      end
      if (ack_hit) begin
         lamps_d.acknowledge_timeout_lamp = 1'b1;
      end
      if (core.bad_io_ref) begin
         lamps_d.addressing_error_lamp = 1'b1;
      end
      if (cyc_over) begin
         lamps_d.cycle_overrun_lamp = 1'b1;
      end
      lamps_d.output_inhibit_lamp = state_q != run_st;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lamps <= '0;
      end else begin
         lamps <= lamps_d;
      end
   end

   always_comb begin
      events = '0;
      events[EV_ACK]  = ack_hit;
      events[EV_ADF]  = core.bad_io_ref;
      events[EV_CYC]  = cyc_over;
      events[EV_INH]  = lamps_d.output_inhibit_lamp && !lamps.output_inhibit_lamp;
      events[EV_SELF] = state_q == run_st && core.self_stop;
      events[EV_RUN]  = lamps_d.run_lamp && !lamps.run_lamp;
   end

   // zero-wait slave: read data is latched in the address phase
   assign acc         = hsel && htrans[1] && hready;
   assign rd_stat_clr = acc && !hwrite && haddr[7:0] == IRQ_STATUS_OFS;
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q  <= '0;
      end else begin
         wr_pend_q <= acc && hwrite;
         wr_ofs_q  <= haddr[7:0];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         maxcyc_q   <= MAXCYC_RST;
         irq_mask_q <= IRQ_MASK_RST[EV_W-1:0];
      end else if (wr_pend_q) begin
         if (wr_ofs_q == MAXCYC_OFS) begin
            maxcyc_q <= hwdata;
         end
         if (wr_ofs_q == IRQ_MASK_OFS) begin
            irq_mask_q <= hwdata[EV_W-1:0];
         end
      end
   end

   // a new event in the cycle of the clearing read stays set
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (rd_stat_clr ? '0 : irq_stat_q) | events;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= '0;
      end else if (acc && !hwrite) begin
         unique case (haddr[7:0])
            MAXCYC_OFS:     hrdata <= maxcyc_q;
            STATUS_OFS:     hrdata <= {22'h00000, state_q, self_q, ovr_q, lamps};
            IRQ_STATUS_OFS: hrdata <= {26'h000000, irq_stat_q};
            IRQ_MASK_OFS:   hrdata <= {26'h000000, irq_mask_q};
            default:        hrdata <= '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence stop_to_run_s;
      state_q == stop_st && sel_rise;
   endsequence

   sequence erase_done_s;
      state_q == erase_st && core.erase_done;
   endsequence

   run_lamp_on_a: assert property (state_q == run_st && !core.check_active
      |=> lamps.run_lamp && !lamps.stop_lamp) else $error("run lamp pattern wrong");
   exec_in_run_a: assert property (ctl.program_execute |-> $past(state_q) == run_st
      && (lamps.run_lamp || $past(core.check_active))) else $error("execute outside run");
   stop_enter_a: assert property (state_q == run_st && sel_fall
      |=> state_q == stop_st ##1 lamps.stop_lamp || ovr_q) else $error("no stop on selector");
   overall_reset_a: assert property (stop_to_run_s and s3_q.mc_down
      |=> state_q == erase_st && ctl.ram_erase_req) else $error("overall reset not started");
   erase_then_init_a: assert property (erase_done_s
      |=> ctl.ram_init_req && state_q == stop_st && !ovr_q) else $error("init not after erase");
   warm_reset_a: assert property (stop_to_run_s and !s3_q.mc_down && s3_q.mc_up
      |=> ctl.clear_state_req && ctl.restart_startup_block_req && state_q == run_st)
      else $error("reset sequence wrong");
   restart_a: assert property (stop_to_run_s and !s3_q.mc_down && !s3_q.mc_up && !ovr_q
      |=> ctl.resume_req && !ctl.clear_state_req && state_q == run_st) else $error("no resume");
   steady_stop_a: assert property (state_q == stop_st && !self_q && !ovr_q
      && !core.check_active |=> lamps.stop_lamp && !lamps.run_lamp) else $error("stop not steady");
   dark_lamps_a: assert property ((state_q == init_st || core.check_active)
      |=> !lamps.run_lamp && !lamps.stop_lamp) else $error("lamps lit in start or check");
   slow_flash_a: assert property (state_q == stop_st && self_q && !ovr_q
      && !core.check_active |=> lamps.stop_lamp == $past(slow_lvl)) else $error("slow flash wrong");
   rapid_flash_a: assert property (state_q == stop_st && ovr_q && !core.check_active
      |=> lamps.stop_lamp == $past(rapid_lvl) && !lamps.run_lamp) else $error("rapid flash wrong");
   ack_lamp_a: assert property (ack_hit |=> lamps.acknowledge_timeout_lamp)
      else $error("ack timeout lamp not lit");
   ack_absent_a: assert property (core.access_fail && !core.list_hit
      && core.access_addr > IMAGE_LAST && !lamps.acknowledge_timeout_lamp
      |=> !lamps.acknowledge_timeout_lamp) else $error("ack lamp for unrecorded module");
   adf_lamp_a: assert property (core.bad_io_ref |=> lamps.addressing_error_lamp)
      else $error("addressing lamp not lit");
   cycle_lamp_a: assert property (cyc_over |=> lamps.cycle_overrun_lamp && cyc_flag_q)
      else $error("overrun lamp not lit");
   inhibit_out_a: assert property (lamps.output_inhibit_lamp
      |-> !ctl.cmd_output_enable && ctl.outputs_safe) else $error("outputs not inhibited");
endmodule

/* design/mode_panel_pkg.sv */
package mode_panel_pkg;
   localparam int unsigned MCLK_HZ        = 20_000_000;
   localparam int unsigned CYC_PER_MS     = MCLK_HZ / 1000;
   // half periods of the stop lamp flash patterns, rapid is four times the slow rate
   localparam int unsigned SLOW_HALF_MS   = 500;
   localparam int unsigned RAPID_HALF_MS  = 125;
   localparam int unsigned SLOW_HALF_CYC  = SLOW_HALF_MS * CYC_PER_MS;
   localparam int unsigned RAPID_HALF_CYC = RAPID_HALF_MS * CYC_PER_MS;

   localparam logic [7:0]  MAXCYC_OFS     = 8'h00;
   localparam logic [7:0]  STATUS_OFS     = 8'h04;
   localparam logic [7:0]  IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0]  IRQ_MASK_OFS   = 8'h0C;
   localparam logic [31:0] MAXCYC_RST     = 32'h001E8480;
   localparam logic [31:0] IRQ_MASK_RST   = 32'h00000000;

   localparam int unsigned IMAGE_BYTES    = 128;
   localparam logic [7:0]  IMAGE_LAST     = 8'h7F;
   localparam logic [7:0]  STARTUP_BLOCK  = 8'h14;
   localparam logic        OVR_PEND_RST   = 1'b1;

   localparam int unsigned EV_ACK  = 0;
   localparam int unsigned EV_ADF  = 1;
   localparam int unsigned EV_CYC  = 2;
   localparam int unsigned EV_INH  = 3;
   localparam int unsigned EV_SELF = 4;
   localparam int unsigned EV_RUN  = 5;
   localparam int unsigned EV_W    = 6;

   typedef enum logic [1:0] {init_st, stop_st, erase_st, run_st} mode_state_e;

   typedef struct packed {
      logic run_sel;
      logic mc_down;
      logic mc_up;
   } switch_s;

   typedef struct packed {
      logic       init_done;
      logic       check_active;
      logic       self_stop;
      logic       pg_stop;
      logic       mp_stop;
      logic       ovr_request;
      logic       erase_done;
      logic       cycle_start;
      logic       scan_ack;
      logic [6:0] scan_addr;
      logic       access_fail;
      logic [7:0] access_addr;
      logic       list_hit;
      logic       bad_io_ref;
   } core_s;

   typedef struct packed {
      logic run_lamp;
      logic stop_lamp;
      logic acknowledge_timeout_lamp;
      logic addressing_error_lamp;
      logic cycle_overrun_lamp;
      logic output_inhibit_lamp;
   } lamps_s;

   typedef struct packed {
      logic       program_execute;
      logic       ram_erase_req;
      logic       ram_init_req;
      logic       clear_state_req;
      logic       restart_startup_block_req;
      logic [7:0] startup_block;
      logic       resume_req;
      logic       cmd_output_enable;
      logic       outputs_safe;
   } ctl_s;
endpackage

/* verification/controller_mode_status_panel_tb_top.sv */
`timescale 1ns/1ns
module controller_mode_status_panel_tb_top;
   import mode_panel_pkg::*;
   localparam int unsigned SLOWH  = 16;
   localparam int unsigned RAPIDH = 4;
   logic        mclk, nrst, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  seen;
   switch_s     sw;
   core_s       core;
   lamps_s      lamps;
   ctl_s        ctl;
   int          failures, tests_run, cyc, h;

   mode_panel #(.SLOW_HALF(SLOWH), .RAPID_HALF(RAPIDH)) dut_u (.mclk(mclk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .sw_pins(sw), .core(core), .lamps(lamps), .ctl(ctl), .irq(irq));
   op_core_model p_u (.mclk(mclk), .ctl(ctl), .sw(sw), .core(core));

   always #25 mclk = ~mclk;
   // request pulses last one cycle, so they are latched here for later checks
   always @(posedge mclk) seen <= seen | {ctl.ram_erase_req, ctl.ram_init_req,
      ctl.clear_state_req, ctl.restart_startup_block_req, ctl.resume_req};
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         close_out;
      end
   end

   task automatic close_out;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask

   task automatic nap(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", hresp, 0);
   endtask

   task automatic ev(input int k);
      core_s v;
      v = '0;
      case (k)
         0: v.init_done = 1'b1;
         1: v.self_stop = 1'b1;
         2: v.pg_stop = 1'b1;
         3: v.mp_stop = 1'b1;
         4: v.bad_io_ref = 1'b1;
         6: v.ovr_request = 1'b1;
         default: v.cycle_start = 1'b1;
      endcase
      p_u.pulse(v);
      nap(4);
   endtask

   task automatic acc(input logic scan, input logic [7:0] a);
      core_s v;
      v = '0;
      v.scan_ack = scan;
      v.scan_addr = a[6:0];
      v.access_fail = !scan;
      v.access_addr = a;
      p_u.pulse(v);
      nap(4);
   endtask

   task automatic half_of(output int n);
      logic l;
      int   w;
      @(negedge mclk);
      l = lamps.stop_lamp;
      w = 0;
      while (lamps.stop_lamp === l && w < 200) begin
         @(negedge mclk);
         w++;
      end
      l = lamps.stop_lamp;
      n = 0;
      while (lamps.stop_lamp === l && n < 200) begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic steady;
      int bad;
      bad = 0;
      repeat (40) begin
         @(negedge mclk);
         if (lamps.stop_lamp !== 1'b1 || lamps.run_lamp !== 1'b0) bad++;
      end
      chk("steady stop", bad, 0);
   endtask

   task automatic t_init;
      nap(2);
      chk("init dark", {lamps.run_lamp, lamps.stop_lamp}, 0);
      chk("inhibit", {lamps.output_inhibit_lamp, ctl.outputs_safe, ctl.cmd_output_enable}, 6);
      bus(0, MAXCYC_OFS, 0);
      chk("maxcyc", rd, 32'h001E8480);
      bus(0, IRQ_MASK_OFS, 0);
      chk("mask", rd, 32'h00000000);
      bus(0, 8'h10, 0);
      chk("unmapped", rd, 32'h00000000);
      ev(0);
      half_of(h);
      chk("rapid half", h, RAPIDH);
      chk("run off", lamps.run_lamp, 0);
   endtask

   task automatic t_overall;
      for (int i = 0; i < 2; i++) begin
         p_u.erase_wait = i * 24 + 1;
         p_u.set_sw(0, 1, 0);
         half_of(h);
         chk("pending half", h, RAPIDH);
         seen = '0;
         p_u.set_sw(1, 1, 0);
         nap(30);
         chk("erase then init", seen[4:3], 2'b11);
         steady;
         p_u.set_sw(0, 0, 0);
      end
   endtask

   task automatic t_reset;
      seen = '0;
      p_u.set_sw(1, 0, 1);
      nap(2);
      chk("clear startup", seen[2:1], 2'b11);
      chk("block", ctl.startup_block, 8'h14);
      chk("run lamps", {lamps.run_lamp, lamps.stop_lamp, ctl.program_execute}, 5);
      chk("outputs", {lamps.output_inhibit_lamp, ctl.outputs_safe, ctl.cmd_output_enable}, 1);
      p_u.set_sw(1, 0, 0);
   endtask

   task automatic t_faults;
      bus(1, IRQ_MASK_OFS, 32'h00000002);
      bus(0, IRQ_STATUS_OFS, 0);
      nap(2);
      chk("irq idle", irq, 0);
      acc(0, 8'h06);
      chk("absent module", lamps.acknowledge_timeout_lamp, 0);
      acc(1, 8'h05);
      acc(0, 8'h85);
      chk("beyond image", lamps.acknowledge_timeout_lamp, 0);
      acc(0, 8'h05);
      chk("ack lamp", lamps.acknowledge_timeout_lamp, 1);
      chk("masked", irq, 0);
      ev(4);
      chk("adf lamp", lamps.addressing_error_lamp, 1);
      chk("irq set", irq, 1);
      bus(0, IRQ_STATUS_OFS, 0);
      chk("irq status", rd, 32'h00000003);
      nap(3);
      chk("irq clear", irq, 0);
      bus(1, STATUS_OFS, 0);
      bus(0, STATUS_OFS, 0);
      chk("state run", rd[9:8], 2'd3);
      ev(5);
      bus(1, MAXCYC_OFS, 32'd20);
      nap(4);
      chk("in time", lamps.cycle_overrun_lamp, 0);
      nap(20);
      chk("overrun", lamps.cycle_overrun_lamp, 1);
   endtask

   task automatic t_stops;
      ev(1);
      half_of(h);
      chk("slow half", h, SLOWH);
      chk("self run off", lamps.run_lamp, 0);
      p_u.set_sw(0, 0, 0);
      steady;
      for (int k = 0; k < 3; k++) begin
         seen = '0;
         p_u.set_sw(1, 0, 0);
         chk("resume", {seen[0], lamps.run_lamp}, 3);
         if (k < 2) begin
            ev(k + 2);
         end else begin
            p_u.set_sw(0, 0, 0);
         end
         steady;
         chk("safe", {lamps.output_inhibit_lamp, ctl.outputs_safe}, 3);
         p_u.set_sw(0, 0, 0);
      end
      p_u.set_sw(1, 0, 0);
      p_u.base.check_active <= 1'b1;
      nap(4);
      chk("check dark", {lamps.run_lamp, lamps.stop_lamp}, 0);
      @(posedge mclk);
      p_u.base.check_active <= 1'b0;
      p_u.set_sw(0, 0, 0);
      ev(6);
      half_of(h);
      chk("core pending", h, RAPIDH);
      seen = '0;
      p_u.set_sw(1, 0, 0);
      chk("no resume", {seen[0], lamps.run_lamp}, 0);
      bus(0, STATUS_OFS, 0);
      chk("stays stop", rd[9:8], 2'd1);
   endtask

   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      seen = '0;
      failures = 0;
      tests_run = 0;
      cyc = 0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      t_init;
      t_overall;
      t_reset;
      t_faults;
      t_stops;
      close_out;
   end
endmodule

/* verification/op_core_model.sv */
`timescale 1ns/1ns
module op_core_model
   import mode_panel_pkg::*;
(
   input  wire logic                  mclk,
   input  wire mode_panel_pkg::ctl_s  ctl,
   output mode_panel_pkg::switch_s    sw,
   output mode_panel_pkg::core_s      core
);
   core_s base;
   core_s ev;
   logic  done;
   int    erase_wait;
   int    cnt;

   initial begin
      sw = '0;
      base = '0;
      ev = '0;
      done = 1'b0;
      erase_wait = 1;
      cnt = 0;
   end

   always_comb begin
      core = base | ev;
      core.erase_done = done;
   end

   // the erase answer can be delayed so that a slow core is also exercised
   always @(posedge mclk) begin
      if (ctl.ram_erase_req) begin
         cnt <= erase_wait;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      done <= (cnt == 1);
   end

   task automatic pulse(input core_s v);
      @(posedge mclk);
      ev <= v;
      @(posedge mclk);
      ev <= '0;
   endtask

   // switches held well past the input filter before anything else moves
   task automatic set_sw(input logic run, input logic down, input logic up);
      @(posedge mclk);
      sw <= {run, down, up};
      repeat (10) @(posedge mclk);
   endtask
endmodule
